// >>> rtl/mwv_pkg.sv
/*
 * Shared constants and types for the Manchester word validator.
 * Assumes the core clock is the oversampling clock, twelve times the bit rate.
 */
package mwv_pkg;

	// The clock is supplied at this multiple of the serial bit rate.
	localparam int OVS_PER_BIT = 12;
	localparam int CLK_PERIOD_NS = 8;

	// Bit phase counter: one bit period spans phases 0 to 11.
	localparam logic [3:0] PH_LAST = 4'(OVS_PER_BIT - 1);
	localparam logic [3:0] PH_RISE = 4'h5;
	localparam logic [3:0] PH_SAMPLE_A = 4'h3;
	localparam logic [3:0] PH_SAMPLE_B = 4'h9;
	localparam logic [3:0] PH_MID_LO = 4'h4;
	localparam logic [3:0] PH_MID_HI = 4'h8;
	localparam logic [3:0] PH_MID_NEXT = 4'h7;
	localparam logic [3:0] PH_AFTER_SYNC = 4'h1;

	// Transition spacing windows, in oversampling clock periods.
	localparam logic [4:0] SPAN_SHORT_MIN = 5'h04;
	localparam logic [4:0] SPAN_SHORT_MAX = 5'h08;
	localparam logic [4:0] SPAN_LONG_MIN = 5'h0a;
	localparam logic [4:0] SPAN_LONG_MAX = 5'h0e;
	localparam logic [4:0] SPAN_SYNC_MIN = 5'h0f;
	localparam logic [4:0] SPAN_SYNC_MAX = 5'h15;
	localparam logic [4:0] SPAN_SAT = 5'h1f;
	localparam logic [4:0] SPAN_ONE = 5'h01;
	localparam logic [4:0] SYNC_HALF = 5'h12;

	// Bit counter milestones within a word.
	localparam int PAYLOAD_BITS = 16;
	localparam logic [4:0] CNT_START = 5'h01;
	localparam logic [4:0] CNT_PARITY = 5'(PAYLOAD_BITS);
	localparam logic [4:0] CNT_EVAL = 5'(PAYLOAD_BITS + 1);

	// Self-clear time of the good-word flag, in recovered bit periods.
	localparam int GOOD_BITS = 20;
	localparam logic [7:0] GOOD_CYCLES = 8'(GOOD_BITS * OVS_PER_BIT);

	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_SYNC2 = 2'b01,
		ST_RECV = 2'b10
	} mwv_state_t;

	typedef struct packed {
		logic cmd;
		logic [PAYLOAD_BITS-1:0] data;
	} mwv_word_t;

	localparam int WORD_W = $bits(mwv_word_t);

endpackage

// >>> rtl/mwv_fifo.sv
/*
 * Synchronous FIFO with registered read data and valid/ready on both sides.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module mwv_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [WIDTH-1:0] o_rd_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic out_valid_ff, nxt_out_valid;
	logic [WIDTH-1:0] out_data_ff, nxt_out_data;
	logic push, pop;

	always_comb begin
		push = i_wr_valid && (cnt_ff != CNT_FULL);
		pop = (cnt_ff != '0) && (!out_valid_ff || i_rd_ready);
		nxt_wr_ptr = push ? PTR_W'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
		nxt_rd_ptr = pop ? PTR_W'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = CNT_W'(cnt_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_cnt = CNT_W'(cnt_ff - 1'b1);
		end
		nxt_out_data = pop ? mem[rd_ptr_ff] : out_data_ff;
		nxt_out_valid = pop || (out_valid_ff && !i_rd_ready);
	end

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_wr_data;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
			out_valid_ff <= nxt_out_valid;
			out_data_ff <= nxt_out_data;
		end
	end

	assign o_wr_ready = (cnt_ff != CNT_FULL);
	assign o_rd_valid = out_valid_ff;
	assign o_rd_data = out_data_ff;

endmodule // mwv_fifo

// >>> rtl/mwv_validator.sv
/*
 * Manchester receive decoder: sync hunt, bit recovery, NRZ delivery,
 * odd parity check, good-word flag and a FIFO of received words.
 * Assumes i_core_clk is the oversampling clock at twelve times the bit rate
 * and that the line and abort inputs are asynchronous pins.
 */
`timescale 1ns/100ps

// Summary of operation
// - After sixteen payload bits are delivered, check the word for odd parity.
// - Raise the good-word flag only without coding or parity errors.
// - When the good-word flag rises, sync hunting has already resumed.
// - The good-word flag self-clears twenty bit periods after rising.
// - A new sync plus two good bits clears the good-word flag early.
// - Abort high at a bit clock rising edge returns to sync hunt.
// - A spacing near six clocks is a valid half-bit interval.
// - A spacing near twelve clocks is a valid full-bit interval.
// - Bit clock is the clock divided by twelve, phase locked to data.
// - Sync-type flag is high sixteen bit periods after a command sync.
// - Only a valid sync plus two valid bits starts an output cycle.
module mwv_validator
	import mwv_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_line_data,
	input wire logic i_word_abort_input,
	input wire logic i_word_ready,
	output logic o_recovered_bit_clock,
	output logic o_payload_window,
	output logic o_nrz_serial_out,
	output logic o_sync_type_flag,
	output logic o_word_good_flag,
	output logic o_word_dropped,
	output logic o_word_valid,
	output mwv_word_t o_word
);
	logic line_s1_ff, line_s2_ff, line_d_ff;
	logic abort_s1_ff, abort_s2_ff;
	mwv_state_t state_ff, nxt_state;
	logic [4:0] span_ff, nxt_span, sync_cnt_ff, nxt_sync_cnt;
	logic [4:0] bit_cnt_ff, nxt_bit_cnt;
	logic [3:0] phase_ff, nxt_phase;
	logic half_a_ff, nxt_half_a, half_b_ff, nxt_half_b;
	logic merr_ff, nxt_merr, par_ff, nxt_par;
	logic cmd_pend_ff, nxt_cmd_pend;
	logic [PAYLOAD_BITS-1:0] data_ff, nxt_data;
	logic bitclk_ff, nxt_bitclk, window_ff, nxt_window;
	logic nrz_ff, nxt_nrz, type_ff, nxt_type;
	logic good_ff, nxt_good, drop_ff, nxt_drop;
	logic [7:0] good_tmr_ff, nxt_good_tmr;
	logic edge_seen, is_short, is_long, is_sync, bit_end, bit_rise;
	logic bad_bit, eval_ok, start_ok, fifo_wr_ready, fifo_wr_valid;
	mwv_word_t fifo_wr_word;

	// Both pins pass two flops; the edge detector compares the second with its delayed copy.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			line_s1_ff <= 1'b0;
			line_s2_ff <= 1'b0;
			line_d_ff <= 1'b0;
			abort_s1_ff <= 1'b0;
			abort_s2_ff <= 1'b0;
		end else begin
			line_s1_ff <= i_line_data;
			line_s2_ff <= line_s1_ff;
			line_d_ff <= line_s2_ff;
			abort_s1_ff <= i_word_abort_input;
			abort_s2_ff <= abort_s1_ff;
		end
	end

	always_comb begin
		edge_seen = line_s2_ff ^ line_d_ff;
		is_short = (span_ff >= SPAN_SHORT_MIN) && (span_ff <= SPAN_SHORT_MAX);
		is_long = (span_ff >= SPAN_LONG_MIN) && (span_ff <= SPAN_LONG_MAX);
		is_sync = (span_ff >= SPAN_SYNC_MIN) && (span_ff <= SPAN_SYNC_MAX);
		bit_end = (phase_ff == PH_LAST);
		bit_rise = (phase_ff == PH_RISE);
		bad_bit = (half_a_ff == half_b_ff);
		// Odd parity: the seventeen bits must hold an odd count of ones.
		eval_ok = (state_ff == ST_RECV) && bit_end && (bit_cnt_ff == CNT_EVAL)
			&& !merr_ff && par_ff;
		start_ok = (state_ff == ST_RECV) && bit_end && (bit_cnt_ff == CNT_START)
			&& !merr_ff && !bad_bit;
		fifo_wr_valid = eval_ok;
		fifo_wr_word.cmd = cmd_pend_ff;
		fifo_wr_word.data = data_ff;

		nxt_state = state_ff;
		nxt_span = edge_seen ? SPAN_ONE
			: (span_ff == SPAN_SAT) ? span_ff : 5'(span_ff + 1'b1);
		nxt_sync_cnt = 5'(sync_cnt_ff + 1'b1);
		nxt_bit_cnt = bit_cnt_ff;
		nxt_phase = bit_end ? 4'h0 : 4'(phase_ff + 1'b1);
		nxt_half_a = half_a_ff;
		nxt_half_b = half_b_ff;
		nxt_merr = merr_ff;
		nxt_par = par_ff;
		nxt_cmd_pend = cmd_pend_ff;
		nxt_data = data_ff;
		nxt_window = window_ff;
		nxt_nrz = nrz_ff;
		nxt_type = type_ff;
		nxt_drop = eval_ok && !fifo_wr_ready;

		unique case (state_ff)
			ST_HUNT: begin
				// The mid-sync edge ends a first half of sync length.
				if (edge_seen && is_sync) begin
					nxt_state = ST_SYNC2;
					nxt_cmd_pend = line_d_ff;
					nxt_sync_cnt = SPAN_ONE;
				end
			end
			ST_SYNC2: begin
				// The second sync half may merge with bit 0, so it is timed
				// rather than closed by an edge.
				if (edge_seen && (sync_cnt_ff < SPAN_SYNC_MIN)) begin
					nxt_state = ST_HUNT;
				end else if (sync_cnt_ff == SYNC_HALF) begin
					nxt_state = ST_RECV;
					nxt_phase = PH_AFTER_SYNC;
					nxt_bit_cnt = 5'h00;
					nxt_merr = 1'b0;
					nxt_par = 1'b0;
				end
			end
			ST_RECV: begin
				if (edge_seen) begin
					// The slot after parity carries no data, so activity on an
					// idle or chattering line there must not hold the phase
					// still and postpone the parity verdict.
					if ((phase_ff >= PH_MID_LO) && (phase_ff <= PH_MID_HI)
						&& (bit_cnt_ff <= CNT_PARITY)) begin
						nxt_phase = PH_MID_NEXT;
					end
					if ((bit_cnt_ff != 5'h00) && (bit_cnt_ff <= CNT_PARITY)
						&& !(is_short || is_long)) begin
						nxt_merr = 1'b1;
					end
				end
				if (phase_ff == PH_SAMPLE_A) begin
					nxt_half_a = line_s2_ff;
				end
				if (phase_ff == PH_SAMPLE_B) begin
					nxt_half_b = line_s2_ff;
				end
				if (bit_end) begin
					nxt_bit_cnt = 5'(bit_cnt_ff + 1'b1);
					if (bit_cnt_ff <= CNT_PARITY) begin
						nxt_merr = nxt_merr || bad_bit;
						nxt_par = par_ff ^ half_a_ff;
						if (bit_cnt_ff < CNT_PARITY) begin
							nxt_data = {data_ff[PAYLOAD_BITS-2:0], half_a_ff};
						end
						// Delivery lags reception by one bit.
						nxt_nrz = data_ff[0];
					end
					if (bit_cnt_ff == CNT_START) begin
						if (start_ok) begin
							nxt_window = 1'b1;
							nxt_type = cmd_pend_ff;
						end else begin
							nxt_state = ST_HUNT;
						end
					end
					if (bit_cnt_ff == CNT_EVAL) begin
						nxt_state = ST_HUNT;
						nxt_window = 1'b0;
						nxt_type = 1'b0;
						nxt_nrz = 1'b0;
					end
				end
			end
		endcase

		if (bit_rise && abort_s2_ff) begin
			nxt_state = ST_HUNT;
			nxt_window = 1'b0;
			nxt_type = 1'b0;
			nxt_nrz = 1'b0;
		end

		nxt_bitclk = (nxt_phase > PH_RISE);

		nxt_good = good_ff;
		nxt_good_tmr = good_ff ? 8'(good_tmr_ff - 1'b1) : good_tmr_ff;
		if (start_ok || (good_ff && (good_tmr_ff == 8'h01))) begin
			nxt_good = 1'b0;
		end
		// A new good word wins over any clear in the same cycle.
		if (eval_ok) begin
			nxt_good = 1'b1;
			nxt_good_tmr = GOOD_CYCLES;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_ff <= ST_HUNT;
			span_ff <= SPAN_SAT;
			sync_cnt_ff <= '0;
			bit_cnt_ff <= '0;
			phase_ff <= '0;
			half_a_ff <= 1'b0;
			half_b_ff <= 1'b0;
			merr_ff <= 1'b0;
			par_ff <= 1'b0;
			cmd_pend_ff <= 1'b0;
			data_ff <= '0;
			bitclk_ff <= 1'b0;
			window_ff <= 1'b0;
			nrz_ff <= 1'b0;
			type_ff <= 1'b0;
			good_ff <= 1'b0;
			good_tmr_ff <= '0;
			drop_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			span_ff <= nxt_span;
			sync_cnt_ff <= nxt_sync_cnt;
			bit_cnt_ff <= nxt_bit_cnt;
			phase_ff <= nxt_phase;
			half_a_ff <= nxt_half_a;
			half_b_ff <= nxt_half_b;
			merr_ff <= nxt_merr;
			par_ff <= nxt_par;
			cmd_pend_ff <= nxt_cmd_pend;
			data_ff <= nxt_data;
			bitclk_ff <= nxt_bitclk;
			window_ff <= nxt_window;
			nrz_ff <= nxt_nrz;
			type_ff <= nxt_type;
			good_ff <= nxt_good;
			good_tmr_ff <= nxt_good_tmr;
			drop_ff <= nxt_drop;
		end
	end

	// The line cannot be stalled, so a full FIFO drops the word and says so.
	mwv_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_wr_valid(fifo_wr_valid),
		.o_wr_ready(fifo_wr_ready),
		.i_wr_data(fifo_wr_word),
		.o_rd_valid(o_word_valid),
		.i_rd_ready(i_word_ready),
		.o_rd_data(o_word)
	);

	assign o_recovered_bit_clock = bitclk_ff;
	assign o_payload_window = window_ff;
	assign o_nrz_serial_out = nrz_ff;
	assign o_sync_type_flag = type_ff;
	assign o_word_good_flag = good_ff;
	assign o_word_dropped = drop_ff;

	AST_GOOD_CAUSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_word_good_flag) |-> $past(eval_ok))
		else $error("Good flag rose without a clean parity-checked word.");
	AST_EVAL_AT_END: assert property (@(posedge i_core_clk) disable iff (i_rst)
		eval_ok |-> bit_cnt_ff == CNT_EVAL && !merr_ff)
		else $error("Word evaluated before all bits were delivered.");
	AST_HUNT_AT_GOOD: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_word_good_flag) |-> state_ff == ST_HUNT)
		else $error("Not hunting for sync when the good flag rose.");
	AST_GOOD_TIMEOUT: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_word_good_flag) |-> ##[1:240] !o_word_good_flag)
		else $error("Good flag did not self-clear in time.");
	AST_EARLY_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_payload_window) |-> !o_word_good_flag)
		else $error("Good flag survived the start of a new word.");
	AST_ABORT: assert property (@(posedge i_core_clk) disable iff (i_rst)
		bit_rise && abort_s2_ff |=> state_ff == ST_HUNT && !o_payload_window)
		else $error("Abort at bit clock rise did not reset the receiver.");
	AST_WINDOW_LEN: assert property (@(posedge i_core_clk)
		disable iff (i_rst || abort_s2_ff)
		$rose(o_payload_window) |-> ##191 o_payload_window ##1 !o_payload_window)
		else $error("Payload window did not last sixteen bit periods.");
	AST_TYPE_IN_WINDOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_sync_type_flag |-> o_payload_window)
		else $error("Sync-type flag high outside the payload window.");
	AST_START: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_payload_window) |-> $past(start_ok) && bit_cnt_ff == 5'h02)
		else $error("Output cycle began without sync and two good bits.");
	AST_CODE_ERR: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_ff == ST_RECV && edge_seen && bit_cnt_ff != 5'h00
		&& bit_cnt_ff <= CNT_PARITY && !is_short && !is_long |=> merr_ff)
		else $error("Bad transition spacing was not recorded.");
	AST_PHASE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		phase_ff <= PH_LAST)
		else $error("Bit phase counter left its range.");

endmodule // mwv_validator

// >>> verification/mwv_line_model.sv
/* Line-side partner: a Manchester II word sender and the NRZ shift register.
   Assumes the bench calls send() and the clock runs at twelve per bit. */
`timescale 1ns/100ps
module mwv_line_model
	import mwv_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_win,
	input wire logic i_bclk,
	input wire logic i_nrz,
	input wire logic i_type,
	output logic o_line,
	output logic [15:0] o_cap,
	output logic [4:0] o_cnt,
	output logic [1:0] o_tsum,
	output int o_per_err
);
	logic busy = 1'b0;
	logic lvl = 1'b0;
	logic bclk_q = 1'b0;
	int per = 0;
	initial o_line = 1'b0;
	// A released line toggles every cycle, so no stale level reads as data.
	always @(negedge i_core_clk) begin
		o_line <= busy ? lvl : ~o_line;
	end
	task automatic half(input logic v, input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			busy = 1'b1;
			lvl = v;
		end
	endtask
	task automatic send(input logic c, input logic [15:0] d,
		input logic bp, input logic bc, input int sl);
		logic [16:0] w;
		w = {d, ~^d ^ bp};
		half(~c, 2);
		half(c, sl);
		half(~c, sl);
		for (int i = 16; i >= 0; i--) begin
			half(w[i], 6);
			half(w[i] ^ !(bc && i == 8), 6);
		end
		@(posedge i_core_clk);
		busy = 1'b0;
	endtask
	// Takes the NRZ bit at each bit clock rise while the window is open.
	always @(posedge i_core_clk) begin
		bclk_q <= i_bclk;
		per <= per + 1;
		if (!i_win) begin
			o_cnt <= 5'h00;
			o_tsum <= 2'b01;
		end
		if (i_bclk && !bclk_q) begin
			per <= 1;
			if (i_win && o_cnt != 5'h00 && per != OVS_PER_BIT)
				o_per_err <= o_per_err + 1;
			if (i_win) begin
				o_cap <= {o_cap[14:0], i_nrz};
				o_cnt <= o_cnt + 5'h01;
				o_tsum <= {o_tsum[1] | i_type, o_tsum[0] & i_type};
			end
		end
	end
endmodule // mwv_line_model

// >>> verification/mwv_validator_test.sv
/* Self-checking bench for the Manchester word validator.
   Assumes the line model sends words; a watcher checks results in order. */
`timescale 1ns/100ps
module mwv_validator_test
	import mwv_pkg::*;
;
	typedef struct packed {
		logic good;
		logic ab;
		mwv_word_t w;
	} mwv_note_t;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_word_abort_input = 1'b0;
	logic i_word_ready = 1'b1;
	logic o_recovered_bit_clock, o_payload_window, o_nrz_serial_out;
	logic o_sync_type_flag, o_word_good_flag, o_word_dropped, o_word_valid;
	logic line, win_q = 1'b0, good_q = 1'b0;
	mwv_word_t o_word;
	logic [15:0] cap;
	logic [4:0] cnt;
	logic [1:0] tsum;
	logic [31:0] seed = 32'h7fb0;
	mwv_note_t nq[$];
	mwv_word_t wq[$];
	mwv_note_t cur;
	int miscompares = 0, tests_run = 0, cycles = 0, per_err;
	int drops = 0, exp_drops = 0, glen = 0, rise_w = 0, gchk = 0;
	int room = 1000;
	always #(CLK_PERIOD_NS / 2) i_core_clk = ~i_core_clk;
	mwv_validator DUT (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_line_data(line), .i_word_abort_input(i_word_abort_input),
		.i_word_ready(i_word_ready),
		.o_recovered_bit_clock(o_recovered_bit_clock),
		.o_payload_window(o_payload_window),
		.o_nrz_serial_out(o_nrz_serial_out),
		.o_sync_type_flag(o_sync_type_flag),
		.o_word_good_flag(o_word_good_flag), .o_word_dropped(o_word_dropped),
		.o_word_valid(o_word_valid), .o_word(o_word));
	mwv_line_model line_model (.i_core_clk(i_core_clk),
		.i_win(o_payload_window), .i_bclk(o_recovered_bit_clock),
		.i_nrz(o_nrz_serial_out), .i_type(o_sync_type_flag), .o_line(line),
		.o_cap(cap), .o_cnt(cnt), .o_tsum(tsum), .o_per_err(per_err));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic check_val(input string nm, input logic [16:0] e,
		input logic [16:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Sends one word and notes what the watcher should see for it.
	task automatic tx(input logic c, input logic bp, input logic bc,
		input logic ab, input int gap);
		mwv_note_t n;
		seed = lfsr(seed);
		n.w = {c, seed[15:0]};
		n.good = !bp && !bc && !ab;
		n.ab = ab;
		nq.push_back(n);
		if (n.good && room > 0) begin
			wq.push_back(n.w);
			room--;
		end else if (n.good)
			exp_drops++;
		line_model.send(c, n.w.data, bp, bc, 18);
		repeat (gap) @(negedge i_core_clk);
	endtask
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	always @(posedge i_core_clk) begin
		if (!i_rst) begin
			win_q <= o_payload_window;
			good_q <= o_word_good_flag;
			glen <= o_word_good_flag ? glen + 1 : 0;
			if (o_word_dropped)
				drops++;
			if (o_word_valid && i_word_ready) begin
				if (wq.size() == 0)
					check_bit("spare word", 1'b0, 1'b1);
				else
					check_val("word", wq.pop_front(), o_word);
			end
			if (good_q && !o_word_good_flag && !o_payload_window)
				check_val("good time", 17'(GOOD_CYCLES), 17'(glen));
			if (!win_q && o_payload_window)
				rise_w = 3;
			if (rise_w > 0 && --rise_w == 0)
				check_bit("good at start", 1'b0, o_word_good_flag);
			if (win_q && !o_payload_window) begin
				if (nq.size() == 0)
					check_bit("spare window", 1'b0, 1'b1);
				else begin
					cur = nq.pop_front();
					gchk = 3;
					if (!cur.ab) begin
						check_val("nrz", {1'b0, cur.w.data}, {1'b0, cap});
						check_val("bits", 17'(PAYLOAD_BITS), 17'(cnt));
						check_val("type", {15'h0, {2{cur.w.cmd}}}, 17'(tsum));
					end
				end
			end
			if (gchk > 0 && --gchk == 0)
				check_bit("good", cur.good, o_word_good_flag);
		end
	end
	initial begin
		repeat (8) @(negedge i_core_clk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_core_clk);
		for (int k = 0; k < 4; k++)
			tx(k[0], 1'b0, 1'b0, 1'b0, 300);
		tx(1'b1, 1'b1, 1'b0, 1'b0, 40);
		tx(1'b0, 1'b0, 1'b1, 1'b0, 40);
		tx(1'b1, 1'b0, 1'b0, 1'b0, 0);
		tx(1'b0, 1'b0, 1'b0, 1'b0, 40);
		line_model.send(1'b1, 16'h0000, 1'b0, 1'b0, 26);
		fork
			tx(1'b1, 1'b0, 1'b0, 1'b1, 40);
			begin
				repeat (120) @(negedge i_core_clk);
				i_word_abort_input = 1'b1;
				repeat (24) @(negedge i_core_clk);
				i_word_abort_input = 1'b0;
			end
		join
		tx(1'b0, 1'b0, 1'b0, 1'b0, 40);
		// The consumer stalls until one word past full, then drains at random.
		i_word_ready = 1'b0;
		room = 17;
		repeat (18)
			tx(seed[3], 1'b0, 1'b0, 1'b0, 0);
		repeat (40) @(negedge i_core_clk);
		for (int k = 0; k < 3000 && wq.size() > 0; k++) begin
			@(negedge i_core_clk);
			seed = lfsr(seed);
			i_word_ready = seed[0];
		end
		i_word_ready = 1'b1;
		repeat (20) @(negedge i_core_clk);
		check_val("queued", 17'h0, 17'(wq.size()));
		check_val("drops", 17'(exp_drops), 17'(drops));
		check_val("windows left", 17'h0, 17'(nq.size()));
		check_val("bit period", 17'h0, 17'(per_err));
		give_verdict();
	end
endmodule // mwv_validator_test
